// [design/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// [design/touch_adc_params.svh]
`ifndef TOUCH_ADC_PARAMS_SVH
`define TOUCH_ADC_PARAMS_SVH
// How it works
// - A new conversion can start every 15 serial clocks, overlapping result tail.
// - Results are unsigned straight binary, zero low, all ones full scale.
// - Eight-bit conversions end four serial clocks before twelve-bit ones.
// - Power select 11 keeps full power; 00 powers down between conversions.
// - Auto power-down covers all idle time between conversions.
// - Single-ended reference: drive switches closed only while acquiring.
// - Differential reference: switches closed through acquisition and conversion.
// - One successive-approximation decision on each serial clock rising edge.
// - Serial input ignored until a high marker bit starts a command byte.
// - Resolution bit low selects twelve bits, high selects eight bits.
// - Reference bit high selects single-ended, low selects differential.
// - After the command byte, twelve clocks convert; last bit shows one later.

// Command byte positions, counted as received bits with the marker as bit 1
`define CMD_BITS 5'h08
`define CMD_CHAN_LAST 5'h04
`define CMD_MODE_POS 5'h05
`define CMD_REF_POS 5'h06
`define CMD_PD1_POS 5'h07

// Framing
`define FRAME_CYCLES 5'h0F
`define SHORT_TRIM 5'h04

// Power select codes and reset values
`define PD_FULL 2'h3
`define PD_AUTO 2'h0
`define PD_RESET 2'h0
`define CHAN_RESET 3'h0

// Synchroniser reset pattern: serial clock, select, data, comparator
`define SYNC_RESET 4'h4
`endif

// [design/touch_adc_pkg.sv]
package touch_adc_pkg;
  typedef enum logic [1:0] {CMD_HUNT, CMD_SHIFT, CMD_WAIT} cmd_state_t;
  typedef logic [1:0] power_sel_t;
endpackage

// [design/touch_adc_serial_sequencer.sv]
`timescale 1ns/100ps
`include "touch_adc_params.svh"
module touch_adc_serial_sequencer
  import touch_adc_pkg::*;
#(
  parameter int RESULT_BITS = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serial_clock_in,
  input wire logic cs_n,
  input wire logic din,
  input wire logic comp_in,
  output logic dout,
  output logic dout_oe,
  output logic busy,
  output logic sample_track,
  output logic switch_on,
  output logic powered,
  output logic [2:0] input_channel_select,
  output logic reference_mode_select,
  output logic eight_bit_mode,
  output logic [1:0] power_down_select,
  output logic [RESULT_BITS-1:0] sar_trial,
  output logic [RESULT_BITS-1:0] result,
  output logic result_valid
);
  if (RESULT_BITS < 9 || RESULT_BITS > 16) begin : g_bad_width
    $error("RESULT_BITS must lie between 9 and 16");
  end

  localparam logic [4:0] FULL_BITS = 5'(RESULT_BITS);
  localparam logic [4:0] SHORT_BITS = FULL_BITS - `SHORT_TRIM;
  localparam logic [4:0] FULL_GAP = `FRAME_CYCLES - `CMD_BITS;
  localparam logic [RESULT_BITS-1:0] TOP_BIT = {1'b1, {(RESULT_BITS-1){1'b0}}};

  logic sclk_s, csn_s, din_s, comp_s, sclk_d_reg, sclk_d_next;
  logic rise, fall, hunt_due, last_dec;
  logic [4:0] nbits, hunt_at, cmd_cnt_reg, cmd_cnt_next, dec_cnt_reg, dec_cnt_next;

  cmd_state_t cmd_state_reg, cmd_state_next;
  logic [2:0] chan_sh_reg, chan_sh_next, chan_reg, chan_next;
  logic mode_sh_reg, mode_sh_next, pd_hi_reg, pd_hi_next, acq_reg, acq_next;
  logic conv_run_reg, conv_run_next, last_bit_reg, last_bit_next, out_pend_reg, out_pend_next;
  logic comp_seen_reg, comp_seen_next, comp_all_reg, comp_all_next, res8_reg, res8_next;
  logic ref_sel_reg, ref_sel_next, result_valid_reg, result_valid_next, dout_reg, dout_next;
  logic dout_oe_reg, dout_oe_next, busy_reg, busy_next, switch_reg, switch_next;
  logic powered_reg, powered_next;
  logic [RESULT_BITS-1:0] mask_reg, mask_next, trial_reg, trial_next, decided;
  logic [RESULT_BITS-1:0] result_reg, result_next;
  power_sel_t pd_reg, pd_next;

  pin_sync #(.WIDTH(4), .RESET_VAL(`SYNC_RESET)) pin_sync_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .d({serial_clock_in, cs_n, din, comp_in}),
    .q({sclk_s, csn_s, din_s, comp_s})
  );

  // Serial clock edges only count while the chip is selected
  assign rise = !csn_s && sclk_s && !sclk_d_reg;
  assign fall = !csn_s && !sclk_s && sclk_d_reg;
  assign nbits = res8_reg ? SHORT_BITS : FULL_BITS;
  assign hunt_at = 5'(nbits - FULL_BITS + FULL_GAP);
  assign hunt_due = 5'(dec_cnt_reg + 5'h01) >= hunt_at;
  assign last_dec = 5'(dec_cnt_reg + 5'h01) == nbits;
  assign decided = comp_s ? trial_reg : (trial_reg & ~mask_reg);

  always_comb begin
    sclk_d_next = sclk_s;
    cmd_state_next = cmd_state_reg;
    cmd_cnt_next = cmd_cnt_reg;
    chan_sh_next = chan_sh_reg;
    mode_sh_next = mode_sh_reg;
    pd_hi_next = pd_hi_reg;
    acq_next = acq_reg;
    conv_run_next = conv_run_reg;
    dec_cnt_next = dec_cnt_reg;
    mask_next = mask_reg;
    trial_next = trial_reg;
    last_bit_next = last_bit_reg;
    out_pend_next = out_pend_reg;
    comp_seen_next = comp_seen_reg;
    comp_all_next = comp_all_reg;
    res8_next = res8_reg;
    ref_sel_next = ref_sel_reg;
    chan_next = chan_reg;
    pd_next = pd_reg;
    result_next = result_reg;
    result_valid_next = 1'b0;
    dout_next = dout_reg;
    if (rise) begin
      if (conv_run_reg) begin
        dec_cnt_next = 5'(dec_cnt_reg + 5'h01);
        mask_next = mask_reg >> 1;
        last_bit_next = comp_s;
        out_pend_next = 1'b1;
        comp_seen_next = comp_seen_reg | comp_s;
        comp_all_next = comp_all_reg & comp_s;
        if (last_dec) begin
          // Short mode never reaches the low bits, so they stay zero
          trial_next = decided;
          conv_run_next = 1'b0;
          result_next = decided;
          result_valid_next = 1'b1;
        end else begin
          trial_next = decided | (mask_reg >> 1);
        end
      end
      case (cmd_state_reg)
        CMD_HUNT: begin
          if (din_s) begin
            cmd_cnt_next = 5'h01;
            cmd_state_next = CMD_SHIFT;
          end
        end
        CMD_SHIFT: begin
          cmd_cnt_next = 5'(cmd_cnt_reg + 5'h01);
          if (cmd_cnt_next <= `CMD_CHAN_LAST) begin
            chan_sh_next = {chan_sh_reg[1:0], din_s};
          end
          if (cmd_cnt_next == `CMD_MODE_POS) begin
            // New channel applies only once the previous conversion is done
            mode_sh_next = din_s;
            chan_next = chan_sh_reg;
            acq_next = 1'b1;
          end
          if (cmd_cnt_next == `CMD_REF_POS) begin
            ref_sel_next = din_s;
          end
          if (cmd_cnt_next == `CMD_PD1_POS) begin
            pd_hi_next = din_s;
          end
          if (cmd_cnt_next == `CMD_BITS) begin
            pd_next = {pd_hi_reg, din_s};
            res8_next = mode_sh_reg;
            acq_next = 1'b0;
            conv_run_next = 1'b1;
            dec_cnt_next = 5'h00;
            mask_next = TOP_BIT;
            trial_next = TOP_BIT;
            comp_seen_next = 1'b0;
            comp_all_next = 1'b1;
            cmd_state_next = CMD_WAIT;
          end
        end
        CMD_WAIT: begin
          if (!conv_run_reg || hunt_due) begin
            cmd_state_next = CMD_HUNT;
          end
        end
        default: cmd_state_next = CMD_HUNT;
      endcase
    end
    if (fall) begin
      // Low between results, as the frame tail expects
      dout_next = out_pend_reg & last_bit_reg;
      out_pend_next = 1'b0;
    end
    dout_oe_next = !csn_s;
    busy_next = conv_run_next;
    switch_next = acq_next || (conv_run_next && !ref_sel_next);
    powered_next = (pd_next == `PD_FULL) || acq_next || conv_run_next;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_reg <= 1'b0;
      cmd_state_reg <= CMD_HUNT;
      cmd_cnt_reg <= 5'h00;
      chan_sh_reg <= `CHAN_RESET;
      mode_sh_reg <= 1'b0;
      pd_hi_reg <= 1'b0;
      acq_reg <= 1'b0;
      conv_run_reg <= 1'b0;
      dec_cnt_reg <= 5'h00;
      mask_reg <= '0;
      trial_reg <= '0;
      last_bit_reg <= 1'b0;
      out_pend_reg <= 1'b0;
      comp_seen_reg <= 1'b0;
      comp_all_reg <= 1'b0;
      res8_reg <= 1'b0;
      ref_sel_reg <= 1'b0;
      chan_reg <= `CHAN_RESET;
      pd_reg <= `PD_RESET;
      result_reg <= '0;
      result_valid_reg <= 1'b0;
      dout_reg <= 1'b0;
      dout_oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      switch_reg <= 1'b0;
      powered_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      cmd_state_reg <= cmd_state_next;
      cmd_cnt_reg <= cmd_cnt_next;
      chan_sh_reg <= chan_sh_next;
      mode_sh_reg <= mode_sh_next;
      pd_hi_reg <= pd_hi_next;
      acq_reg <= acq_next;
      conv_run_reg <= conv_run_next;
      dec_cnt_reg <= dec_cnt_next;
      mask_reg <= mask_next;
      trial_reg <= trial_next;
      last_bit_reg <= last_bit_next;
      out_pend_reg <= out_pend_next;
      comp_seen_reg <= comp_seen_next;
      comp_all_reg <= comp_all_next;
      res8_reg <= res8_next;
      ref_sel_reg <= ref_sel_next;
      chan_reg <= chan_next;
      pd_reg <= pd_next;
      result_reg <= result_next;
      result_valid_reg <= result_valid_next;
      dout_reg <= dout_next;
      dout_oe_reg <= dout_oe_next;
      busy_reg <= busy_next;
      switch_reg <= switch_next;
      powered_reg <= powered_next;
    end
  end

  assign dout = dout_reg;
  assign dout_oe = dout_oe_reg;
  assign busy = busy_reg;
  assign sample_track = acq_reg;
  assign switch_on = switch_reg;
  assign powered = powered_reg;
  assign input_channel_select = chan_reg;
  assign reference_mode_select = ref_sel_reg;
  assign eight_bit_mode = res8_reg;
  assign power_down_select = pd_reg;
  assign sar_trial = trial_reg;
  assign result = result_reg;
  assign result_valid = result_valid_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence cmd_end_s;
    rise && cmd_state_reg == CMD_SHIFT && cmd_cnt_reg == 5'h07;
  endsequence
  sequence bit_ready_s;
    out_pend_reg && fall;
  endsequence

  a_marker_ignored: assert property (
    rise && cmd_state_reg == CMD_HUNT && !din_s |=> cmd_state_reg == CMD_HUNT)
    else $error("command started without a marker bit");
  a_marker_taken: assert property (
    rise && cmd_state_reg == CMD_HUNT && din_s |=> cmd_state_reg == CMD_SHIFT && cmd_cnt_reg == 5'h01)
    else $error("marker bit not taken");
  a_msb_first: assert property (
    cmd_end_s |=> conv_run_reg && mask_reg == TOP_BIT && dec_cnt_reg == 5'h00)
    else $error("conversion did not start at the top bit");
  a_dout_order: assert property (
    bit_ready_s |=> dout_reg == $past(last_bit_reg) && !out_pend_reg)
    else $error("decided bit not shifted out");
  a_one_decision: assert property (
    rise && conv_run_reg && !(cmd_state_reg == CMD_SHIFT && cmd_cnt_reg == 5'h07)
      |=> dec_cnt_reg == 5'($past(dec_cnt_reg) + 5'h01))
    else $error("not one decision per rising edge");
  a_res_select: assert property (
    cmd_end_s |=> res8_reg == $past(mode_sh_reg))
    else $error("resolution bit not applied");
  a_short_length: assert property (
    $fell(conv_run_reg) && res8_reg |-> dec_cnt_reg == FULL_BITS - 5'h04)
    else $error("eight-bit conversion length wrong");
  a_full_length: assert property (
    $fell(conv_run_reg) && !res8_reg |-> dec_cnt_reg == FULL_BITS && result_valid_reg)
    else $error("twelve-bit conversion length wrong");
  a_zero_code: assert property (
    result_valid_reg && !comp_seen_reg |-> result_reg == '0)
    else $error("lowest input did not give zero");
  a_full_scale: assert property (
    result_valid_reg && comp_all_reg && !res8_reg |-> &result_reg)
    else $error("full scale did not give all ones");
  a_full_power: assert property (
    pd_reg == `PD_FULL |-> powered_reg)
    else $error("full power mode powered down");
  a_auto_sleep: assert property (
    pd_reg == `PD_AUTO && !acq_reg && !conv_run_reg |-> !powered_reg)
    else $error("idle without power-down in auto mode");
  a_se_switch: assert property (
    conv_run_reg && !acq_reg && ref_sel_reg |-> !switch_reg)
    else $error("switches closed during single-ended conversion");
  a_diff_switch: assert property (
    (conv_run_reg && !ref_sel_reg) || acq_reg |-> switch_reg)
    else $error("switches open during differential conversion");
  a_ref_select: assert property (
    rise && cmd_state_reg == CMD_SHIFT && cmd_cnt_reg == 5'h05 |=> ref_sel_reg == $past(din_s))
    else $error("reference bit not applied");
  a_overlap_hunt: assert property (
    cmd_state_reg == CMD_WAIT && rise && conv_run_reg && !res8_reg
      && dec_cnt_reg == `FRAME_CYCLES - `CMD_BITS - 5'h01 |=> cmd_state_reg == CMD_HUNT)
    else $error("next marker not accepted fifteen clocks on");
endmodule

// [verif/touch_adc_serial_sequencer_bench.sv]
`timescale 1ns/100ps
module touch_adc_serial_sequencer_bench;
  import touch_adc_pkg::*;
  localparam int HALF = 6;
  localparam int LIMIT = 20000;

  logic core_clk;
  logic resetn;
  logic serial_clock_in;
  logic cs_n;
  logic din;
  logic comp_in;
  logic dout;
  logic dout_oe;
  logic busy;
  logic sample_track;
  logic switch_on;
  logic powered;
  logic [2:0] input_channel_select;
  logic reference_mode_select;
  logic eight_bit_mode;
  logic [1:0] power_down_select;
  logic [11:0] sar_trial;
  logic [11:0] result;
  logic result_valid;
  logic [63:0] rx;
  logic [11:0] level;
  logic [11:0] expect_res;
  logic [7:0] cmds [4] = '{8'hD4, 8'hA3, 8'hBA, 8'hE5};
  logic [11:0] lvls [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h5A3};
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int busy_cnt;
  int sw_busy;
  int pwr_gap;
  int valid_cnt;
  int busy12;
  int acq_cnt;

  // Ideal comparator: high while the input is at or above the trial code
  assign comp_in = (sar_trial <= level);

  touch_adc_serial_sequencer touch_adc_serial_sequencer_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .serial_clock_in(serial_clock_in),
    .cs_n(cs_n),
    .din(din),
    .comp_in(comp_in),
    .dout(dout),
    .dout_oe(dout_oe),
    .busy(busy),
    .sample_track(sample_track),
    .switch_on(switch_on),
    .powered(powered),
    .input_channel_select(input_channel_select),
    .reference_mode_select(reference_mode_select),
    .eight_bit_mode(eight_bit_mode),
    .power_down_select(power_down_select),
    .sar_trial(sar_trial),
    .result(result),
    .result_valid(result_valid)
  );

  touch_host_model #(.HALF(HALF)) touch_host_model_i (
    .core_clk(core_clk),
    .dout(dout),
    .cs_n(cs_n),
    .serial_clock_in(serial_clock_in),
    .din(din),
    .rx(rx)
  );

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  task automatic clear_counts();
    busy_cnt = 0;
    sw_busy = 0;
    pwr_gap = 0;
    valid_cnt = 0;
    acq_cnt = 0;
  endtask

  always @(posedge core_clk) begin
    if (busy === 1'b1) busy_cnt++;
    if (busy === 1'b1 && switch_on === 1'b1) sw_busy++;
    if (busy === 1'b1 && powered !== 1'b1) pwr_gap++;
    if (result_valid === 1'b1) valid_cnt++;
    if (sample_track === 1'b1) acq_cnt++;
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    level = 12'h000;
    repeat (12) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    settle();
    for (int k = 0; k < 4; k++) begin
      level = lvls[k];
      expect_res = cmds[k][3] ? {lvls[k][11:4], 4'h0} : lvls[k];
      clear_counts();
      touch_host_model_i.select();
      check("dout_enable", dout_oe, 1'b1);
      // Leading low bits must be skipped before the marker
      touch_host_model_i.clock_bits({4'h0, cmds[k], 16'h0000}, 28);
      touch_host_model_i.deselect();
      settle();
      check("result", result, expect_res);
      check("wire_bits", rx[14:0], {expect_res, 3'h0});
      check("channel", input_channel_select, cmds[k][6:4]);
      check("reference", reference_mode_select, cmds[k][2]);
      check("resolution", eight_bit_mode, cmds[k][3]);
      check("power_field", power_down_select, cmds[k][1:0]);
      check("powered_idle", powered, cmds[k][1:0] == 2'h3);
      check("switch_in_conv", sw_busy != 0, !cmds[k][2]);
      check("power_in_conv", pwr_gap, 0);
      check("valid_pulses", valid_cnt, 1);
      check("conv_cycles", busy_cnt, (cmds[k][3] ? 8 : 12) * 2 * HALF);
      check("acq_cycles", acq_cnt, 3 * 2 * HALF);
      check("track_idle", sample_track, 1'b0);
      check("switch_idle", switch_on, 1'b0);
      check("dout_release", dout_oe, 1'b0);
      if (k == 0) busy12 = busy_cnt;
      if (k == 2) check("short_conv", busy12 - busy_cnt, 4 * 2 * HALF);
    end
    // Two commands in 15-clock slots, select held low throughout
    level = 12'hA5C;
    clear_counts();
    touch_host_model_i.select();
    touch_host_model_i.clock_bits({8'hD4, 7'h00, 8'hBA, 14'h0000}, 37);
    touch_host_model_i.deselect();
    settle();
    check("overlap_bits", rx[27:0], {12'hA5C, 3'h0, 8'hA5, 5'h00});
    check("overlap_count", valid_cnt, 2);
    check("overlap_result", result, 12'hA50);
    check("overlap_mode", eight_bit_mode, 1'b1);
    check("overlap_busy", busy_cnt, 20 * 2 * HALF);
    check("overlap_track", acq_cnt, 6 * 2 * HALF);
    // Eight-bit frame: next marker after eleven clocks; highs in the gap are ignored
    clear_counts();
    touch_host_model_i.select();
    touch_host_model_i.clock_bits({8'hBA, 3'b110, 8'hD4, 16'h0000}, 35);
    touch_host_model_i.deselect();
    settle();
    check("short_overlap_bits", rx[25:0], {8'hA5, 3'h0, 12'hA5C, 3'h0});
    check("short_overlap_count", valid_cnt, 2);
    check("short_overlap_result", result, 12'hA5C);
    check("short_overlap_busy", busy_cnt, 20 * 2 * HALF);
    print_verdict();
  end
endmodule

// [verif/touch_host_model.sv]
`timescale 1ns/100ps
module touch_host_model #(
  parameter int HALF = 6
) (
  input wire logic core_clk,
  input wire logic dout,
  output logic cs_n,
  output logic serial_clock_in,
  output logic din,
  output logic [63:0] rx
);
  initial begin
    cs_n = 1'b1;
    serial_clock_in = 1'b0;
    din = 1'b0;
    rx = '0;
  end

  task automatic wait_core(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Select stays low for a whole stream of commands
  task automatic select();
    wait_core(1);
    cs_n = 1'b0;
    rx = '0;
    wait_core(HALF);
  endtask

  task automatic deselect();
    wait_core(HALF);
    cs_n = 1'b1;
    // Released line must not look like the last bit
    din = ~din;
  endtask

  // Same clock rate for both resolutions, well inside the faster limit
  // Marker, channel, resolution, reference, power field, MSB first
  // Caller packs 15-bit slots (11-bit after an eight-bit command) to reach the overlapped rate
  task automatic clock_bits(input logic [63:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      wait_core(HALF);
      serial_clock_in = 1'b1;
      rx = {rx[62:0], dout};
      wait_core(HALF);
      serial_clock_in = 1'b0;
    end
  endtask
endmodule
